/* File: sec_cal_store.sv */
// Purpose: six calibration slots with working/prior/oldest rotation
// Assumes: source index is checked by the core before a copy
// Notes: slots are flops standing in for flash; reset reloads defaults
`timescale 1ns/1ps
module sec_cal_store #(
  parameter int CAL_W = 32,
  parameter logic [CAL_W-1:0] FACTORY_CAL = '0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  sec_store_if.cal st
);
  import sec_pkg::*;
  logic [CAL_W-1:0] slot_r [NUM_SLOTS];
  logic [CAL_W-1:0] slot_nxt [NUM_SLOTS];

  always_comb begin
    slot_nxt = slot_r;
    if (st.cal_save || st.cal_copy) begin
      // source is read before the shift, so copying prior still works
      slot_nxt[SLOT_OLDEST] = slot_r[SLOT_PRIOR];
      slot_nxt[SLOT_PRIOR] = slot_r[SLOT_WORK];
      slot_nxt[SLOT_WORK] = st.cal_save ? st.cal_wdata :
                            slot_r[st.cal_src];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_r[i] <= (i >= int'(SLOT_FACTORY)) ? FACTORY_CAL : '0;
      end
    end else begin
      slot_r <= slot_nxt;
    end
  end

  assign st.cal_work = slot_r[SLOT_WORK];
endmodule

/* File: sec_host_model.sv */
// Purpose: remote controller that offers one decoded command at a time
// Assumes: start is a one-cycle request from the bench
// Notes: argument is inverted after the take so stale data never lingers
`timescale 1ns/1ps
module sec_host_model
  import sec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire sec_pkg::sec_cmd_t code_in,
  input wire logic [sec_pkg::ARG_W-1:0] arg_in,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output sec_pkg::sec_cmd_t cmd_code,
  output logic [sec_pkg::ARG_W-1:0] cmd_arg
);
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_valid <= 1'b0;
      cmd_code <= CMD_CLS;
      cmd_arg <= ARG_ZERO;
    end else if (cmd_valid && cmd_ready) begin
      cmd_valid <= 1'b0;
      cmd_arg <= ~cmd_arg;
    end else if (start && !cmd_valid) begin
      cmd_valid <= 1'b1;
      cmd_code <= code_in;
      cmd_arg <= arg_in;
    end
  end
endmodule

/* File: sec_pkg.sv */
// Purpose: shared constants and types for the status, event and command block
// Assumes: 10 MHz core clock, commands arrive already decoded
// Notes: command codes follow the enum order below
package sec_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_TIME_NS = 20000;
  // least time, so round up to whole cycles
  localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) /
                              CLK_PERIOD_NS;
  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);

  localparam int ARG_W = 16;
  localparam int SETPT_W = 16;
  localparam int LOC_W = 6;
  localparam int NUM_LOC = 40;
  localparam int NUM_SLOTS = 6;
  localparam int ERRQ_W = 4;

  localparam logic [ARG_W-1:0] ARG_ZERO = 16'h0000;
  localparam logic [ARG_W-1:0] ARG_BYTE_MAX = 16'h00ff;
  localparam logic [ARG_W-1:0] LOC_MIN = 16'h0001;
  localparam logic [ARG_W-1:0] LOC_MAX = 16'h0028;
  localparam logic [ARG_W-1:0] SLOT_MAX_ARG = 16'h0005;

  localparam int ESR_PON = 7;
  localparam int ESR_CME = 5;
  localparam int ESR_EXE = 4;
  localparam int ESR_DDE = 3;
  localparam int ESR_QYE = 2;
  localparam int ESR_OPC = 0;
  localparam logic [7:0] ESR_USED_MASK = 8'hbd;
  localparam logic [7:0] ESR_RST = 8'h80;
  localparam logic [7:0] ESE_RST = 8'h00;
  localparam logic [7:0] SRE_RST = 8'h00;

  localparam int STB_OPER = 7;
  localparam int STB_RQS = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  localparam int STB_QUES = 3;
  localparam int STB_ERRQ = 2;
  localparam logic [7:0] SRE_WR_MASK = 8'hbf;

  localparam logic [7:0] ASCII_ONE = 8'h31;
  localparam logic DISP_NORMAL = 1'b0;
  localparam logic LIST_DIR_UP = 1'b1;

  typedef enum logic [4:0] {
    CMD_CLS, CMD_ESE, CMD_ESE_Q, CMD_ESR_Q, CMD_IDN_Q, CMD_OPC, CMD_OPC_Q,
    CMD_RCL, CMD_RST, CMD_SAV, CMD_SRE, CMD_SRE_Q, CMD_STB_Q, CMD_TRG,
    CMD_TST_Q, CMD_VOLT, CMD_CURR, CMD_OVP, CMD_OCP, CMD_VTRIG, CMD_ARM,
    CMD_CAL_SAVE, CMD_CAL_COPY, CMD_UNKNOWN
  } sec_cmd_t;

  typedef enum logic [2:0] {
    SLOT_WORK, SLOT_PRIOR, SLOT_OLDEST, SLOT_FACTORY, SLOT_MASTER, SLOT_FIRST
  } sec_slot_t;

  typedef struct packed {
    logic [SETPT_W-1:0] volt;
    logic [SETPT_W-1:0] curr;
    logic [SETPT_W-1:0] ovp;
    logic [SETPT_W-1:0] ocp;
  } sec_setpt_t;
endpackage

/* File: sec_setpt_mem.sv */
// Purpose: forty stored setpoint sets for save and recall
// Assumes: location already range-checked, 1-based
// Notes: read is combinational so recall completes in one cycle
`timescale 1ns/1ps
module sec_setpt_mem (
  input wire logic sys_clk,
  input wire logic sys_rst,
  sec_store_if.mem st
);
  import sec_pkg::*;
  sec_setpt_t mem_r [NUM_LOC];
  logic [LOC_W-1:0] idx;

  always_comb begin
    idx = LOC_W'(st.set_loc - LOC_W'(1));
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_LOC; i++) begin
        mem_r[i] <= '0;
      end
    end else if (st.set_wr) begin
      mem_r[idx] <= st.set_wdata;
    end
  end

  assign st.set_rdata = mem_r[idx];
endmodule

/* File: sec_status_cmd.sv */
// Purpose: common-command interpreter with event status and status byte
// Assumes: parser delivers one decoded command per cmd_valid/cmd_ready
// Notes: numeric answers are binary bytes except the completion answer, ASCII one; identity is a byte stream
// Contract
// - calibration save rotates working, prior, oldest
// - copy into working rotates the same way
// - clear status zeroes events, keeps masks
// - event enable mask eight bits, reset zero
// - event summary is OR of enabled events
// - fixed event status bit layout
// - enable mask query returns stored value
// - event status read returns and clears
// - error events set matching status bits
// - unknown command header sets command error
// - completion bit waits for pending work
// - completion command does not stall commands
// - completion query answers one, holds commands
// - identity string has four comma fields
// - recall loads setpoints from locations 1-40
// - reset clears arming, list up, display normal
// - enabled summaries raise service request
// - armed trigger drives trigger voltage level
// - self-test answers zero pass, one fail
// - request bit clears on poll, master not
`timescale 1ns/1ps
module sec_status_cmd #(
  parameter int CAL_W = 32,
  parameter int IDN_LEN = 41,
  // identity text is an arbitrary neutral value; date field is 10 chars
  parameter logic [8*IDN_LEN-1:0] IDN_TEXT =
    "MAKER,PSU-500-0.4 01-01-2000,S000001,V1.0"
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire sec_pkg::sec_cmd_t cmd_code,
  input wire logic [sec_pkg::ARG_W-1:0] cmd_arg,
  output logic cmd_ready,
  input wire logic exe_err_evt,
  input wire logic dde_err_evt,
  input wire logic qry_err_evt,
  input wire logic oper_evt,
  input wire logic ques_evt,
  input wire logic selftest_fail,
  input wire logic serial_poll,
  input wire logic [CAL_W-1:0] cal_wdata,
  output logic [CAL_W-1:0] cal_active,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  output logic [7:0] status_byte,
  output logic [7:0] event_flags,
  output logic [sec_pkg::SETPT_W-1:0] volt_out,
  output logic [sec_pkg::SETPT_W-1:0] curr_out,
  output logic [sec_pkg::SETPT_W-1:0] ovp_out,
  output logic [sec_pkg::SETPT_W-1:0] ocp_out,
  output logic continuous_arming,
  output logic list_dir_up,
  output logic display_mode_setting,
  output logic op_pending
);
  import sec_pkg::*;
  localparam int IDX_W = $clog2(IDN_LEN);

  if (IDN_LEN < 2 || IDN_LEN > 253) begin
    $error("IDN_LEN out of range");
  end
  if (CAL_W < 1) begin
    $error("CAL_W must be positive");
  end

  function automatic logic in_range(input logic [ARG_W-1:0] v,
                                    input logic [ARG_W-1:0] lo,
                                    input logic [ARG_W-1:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  sec_store_if #(.CAL_W(CAL_W)) st();

  sec_cal_store #(.CAL_W(CAL_W)) u_cal (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .st(st.cal)
  );

  sec_setpt_mem u_mem (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .st(st.mem)
  );

  logic [7:0] ese_r, ese_nxt, esr_r, esr_nxt, sre_r, sre_nxt;
  logic [7:0] stb_r, stb_nxt, stb_base;
  logic oper_r, oper_nxt, ques_r, ques_nxt, rqs_r, rqs_nxt, mss_r, mss_nxt;
  logic [ERRQ_W-1:0] errq_r, errq_nxt;
  sec_setpt_t setpt_r, setpt_nxt;
  logic [SETPT_W-1:0] vtrig_r, vtrig_nxt;
  logic arm_r, arm_nxt, ldir_r, ldir_nxt, disp_r, disp_nxt;
  logic opc_arm_r, opc_arm_nxt, opcq_r, opcq_nxt;
  logic idn_busy_r, idn_busy_nxt;
  logic [IDX_W-1:0] idn_idx_r, idn_idx_nxt;
  logic [SETTLE_W-1:0] settle_r, settle_nxt;
  logic pend_r, pend_nxt, ready_r, ready_nxt;
  logic rsp_valid_r, rsp_valid_nxt, rsp_last_r, rsp_last_nxt;
  logic [7:0] rsp_data_r, rsp_data_nxt, esr_set;
  logic take, esr_clr, sum_clr, out_chg, loc_ok;

  assign take = cmd_valid && ready_r;
  assign loc_ok = in_range(cmd_arg, LOC_MIN, LOC_MAX);
  assign st.cal_save = take && (cmd_code == CMD_CAL_SAVE);
  assign st.cal_copy = take && (cmd_code == CMD_CAL_COPY) &&
                       in_range(cmd_arg, ARG_ZERO, SLOT_MAX_ARG);
  assign st.cal_src = sec_slot_t'(cmd_arg[2:0]);
  assign st.cal_wdata = cal_wdata;
  assign st.set_wr = take && (cmd_code == CMD_SAV) && loc_ok;
  assign st.set_loc = cmd_arg[LOC_W-1:0];
  assign st.set_wdata = setpt_r;

  always_comb begin
    ese_nxt = ese_r;
    sre_nxt = sre_r;
    setpt_nxt = setpt_r;
    vtrig_nxt = vtrig_r;
    arm_nxt = arm_r;
    ldir_nxt = ldir_r;
    disp_nxt = disp_r;
    opc_arm_nxt = opc_arm_r;
    opcq_nxt = opcq_r;
    idn_busy_nxt = idn_busy_r;
    idn_idx_nxt = idn_idx_r;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt = 8'h00;
    rsp_last_nxt = 1'b0;
    esr_set = 8'h00;
    esr_clr = 1'b0;
    sum_clr = 1'b0;
    out_chg = 1'b0;
    esr_set[ESR_EXE] = exe_err_evt;
    esr_set[ESR_DDE] = dde_err_evt;
    esr_set[ESR_QYE] = qry_err_evt;
    if (idn_busy_r) begin
      rsp_valid_nxt = 1'b1;
      rsp_data_nxt = IDN_TEXT[8*(IDN_LEN-1-int'(idn_idx_r)) +: 8];
      idn_idx_nxt = IDX_W'(idn_idx_r + IDX_W'(1));
      if (idn_idx_r == IDX_W'(IDN_LEN - 1)) begin
        idn_busy_nxt = 1'b0;
        rsp_last_nxt = 1'b1;
      end
    end
    if (opcq_r && !pend_r) begin
      opcq_nxt = 1'b0;
      rsp_valid_nxt = 1'b1;
      rsp_data_nxt = ASCII_ONE;
      rsp_last_nxt = 1'b1;
    end
    if (opc_arm_r && !pend_r) begin
      opc_arm_nxt = 1'b0;
      esr_set[ESR_OPC] = 1'b1;
    end
    if (take) begin
      case (cmd_code)
        CMD_CLS: sum_clr = 1'b1;
        CMD_ESE: begin
          if (in_range(cmd_arg, ARG_ZERO, ARG_BYTE_MAX)) begin
            ese_nxt = cmd_arg[7:0];
          end else begin
            esr_set[ESR_EXE] = 1'b1;
          end
        end
        CMD_ESE_Q: begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt = ese_r;
          rsp_last_nxt = 1'b1;
        end
        CMD_ESR_Q: begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt = esr_r;
          rsp_last_nxt = 1'b1;
          esr_clr = 1'b1;
        end
        CMD_IDN_Q: begin
          idn_busy_nxt = 1'b1;
          idn_idx_nxt = '0;
        end
        CMD_OPC: opc_arm_nxt = 1'b1;
        CMD_OPC_Q: opcq_nxt = 1'b1;
        CMD_RCL: begin
          if (loc_ok) begin
            setpt_nxt = st.set_rdata;
            out_chg = 1'b1;
          end else begin
            esr_set[ESR_EXE] = 1'b1;
          end
        end
        CMD_SAV: esr_set[ESR_EXE] = !loc_ok;
        CMD_RST: begin
          setpt_nxt = '0;
          vtrig_nxt = '0;
          arm_nxt = 1'b0;
          ldir_nxt = LIST_DIR_UP;
          disp_nxt = DISP_NORMAL;
          out_chg = 1'b1;
        end
        CMD_SRE: begin
          if (in_range(cmd_arg, ARG_ZERO, ARG_BYTE_MAX)) begin
            sre_nxt = cmd_arg[7:0] & SRE_WR_MASK;
          end else begin
            esr_set[ESR_EXE] = 1'b1;
          end
        end
        CMD_SRE_Q: begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt = sre_r;
          rsp_last_nxt = 1'b1;
        end
        CMD_STB_Q: begin
          // query form shows the master summary, poll form the request bit
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt = {stb_r[7], mss_r, stb_r[5:0]};
          rsp_last_nxt = 1'b1;
        end
        CMD_TRG: begin
          if (arm_r) begin
            setpt_nxt.volt = vtrig_r;
            out_chg = 1'b1;
          end
        end
        CMD_TST_Q: begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt = {7'h00, selftest_fail};
          rsp_last_nxt = 1'b1;
        end
        CMD_VOLT: begin
          setpt_nxt.volt = cmd_arg;
          out_chg = 1'b1;
        end
        CMD_CURR: begin
          setpt_nxt.curr = cmd_arg;
          out_chg = 1'b1;
        end
        CMD_OVP: setpt_nxt.ovp = cmd_arg;
        CMD_OCP: setpt_nxt.ocp = cmd_arg;
        CMD_VTRIG: vtrig_nxt = cmd_arg;
        CMD_ARM: arm_nxt = cmd_arg[0];
        // the rotation itself happens in the slot store
        CMD_CAL_SAVE: out_chg = 1'b0;
        CMD_CAL_COPY: begin
          esr_set[ESR_EXE] = !in_range(cmd_arg, ARG_ZERO, SLOT_MAX_ARG);
        end
        default: esr_set[ESR_CME] = 1'b1;
      endcase
    end
    // a new event in the clearing cycle survives the clear
    esr_nxt = ((esr_clr || sum_clr) ? 8'h00 : esr_r) |
              (esr_set & ESR_USED_MASK);
    oper_nxt = (!sum_clr && oper_r) || oper_evt;
    ques_nxt = (!sum_clr && ques_r) || ques_evt;
    errq_nxt = sum_clr ? '0 : errq_r;
    if ((|esr_set[ESR_CME:ESR_QYE]) && (errq_nxt != '1)) begin
      errq_nxt = ERRQ_W'(errq_nxt + ERRQ_W'(1));
    end
    if (out_chg) begin
      settle_nxt = SETTLE_W'(SETTLE_CYC);
    end else if (settle_r != '0) begin
      settle_nxt = SETTLE_W'(settle_r - SETTLE_W'(1));
    end else begin
      settle_nxt = '0;
    end
    pend_nxt = (settle_nxt != '0);
    stb_base = 8'h00;
    stb_base[STB_OPER] = oper_nxt;
    stb_base[STB_ESB] = |(esr_nxt & ese_nxt);
    stb_base[STB_MAV] = idn_busy_nxt;
    stb_base[STB_QUES] = ques_nxt;
    stb_base[STB_ERRQ] = (errq_nxt != '0);
    mss_nxt = |(stb_base & sre_nxt);
    rqs_nxt = ((rqs_r && !serial_poll && !sum_clr) ||
               (mss_nxt && !mss_r));
    stb_nxt = stb_base;
    stb_nxt[STB_RQS] = rqs_nxt;
    ready_nxt = !(opcq_nxt || idn_busy_nxt);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ese_r <= ESE_RST;
      esr_r <= ESR_RST;
      sre_r <= SRE_RST;
      stb_r <= 8'h00;
      oper_r <= 1'b0;
      ques_r <= 1'b0;
      rqs_r <= 1'b0;
      mss_r <= 1'b0;
      errq_r <= '0;
      setpt_r <= '0;
      vtrig_r <= '0;
      arm_r <= 1'b0;
      ldir_r <= LIST_DIR_UP;
      disp_r <= DISP_NORMAL;
      opc_arm_r <= 1'b0;
      opcq_r <= 1'b0;
      idn_busy_r <= 1'b0;
      idn_idx_r <= '0;
      settle_r <= '0;
      pend_r <= 1'b0;
      ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_last_r <= 1'b0;
    end else begin
      ese_r <= ese_nxt;
      esr_r <= esr_nxt;
      sre_r <= sre_nxt;
      stb_r <= stb_nxt;
      oper_r <= oper_nxt;
      ques_r <= ques_nxt;
      rqs_r <= rqs_nxt;
      mss_r <= mss_nxt;
      errq_r <= errq_nxt;
      setpt_r <= setpt_nxt;
      vtrig_r <= vtrig_nxt;
      arm_r <= arm_nxt;
      ldir_r <= ldir_nxt;
      disp_r <= disp_nxt;
      opc_arm_r <= opc_arm_nxt;
      opcq_r <= opcq_nxt;
      idn_busy_r <= idn_busy_nxt;
      idn_idx_r <= idn_idx_nxt;
      settle_r <= settle_nxt;
      pend_r <= pend_nxt;
      ready_r <= ready_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
      rsp_last_r <= rsp_last_nxt;
    end
  end

  assign cmd_ready = ready_r;
  assign cal_active = st.cal_work;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign rsp_last = rsp_last_r;
  assign status_byte = stb_r;
  assign event_flags = esr_r;
  assign volt_out = setpt_r.volt;
  assign curr_out = setpt_r.curr;
  assign ovp_out = setpt_r.ovp;
  assign ocp_out = setpt_r.ocp;
  assign continuous_arming = arm_r;
  assign list_dir_up = ldir_r;
  assign display_mode_setting = disp_r;
  assign op_pending = pend_r;
endmodule

/* File: sec_status_cmd_assertions.sv */
// Purpose: port-level timing checks of the status and command block
// Assumes: one sys_clk domain, asynchronous active-high reset
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module sec_status_cmd_chk
  import sec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire sec_pkg::sec_cmd_t cmd_code,
  input wire logic [sec_pkg::ARG_W-1:0] cmd_arg,
  input wire logic cmd_ready,
  input wire logic exe_err_evt,
  input wire logic dde_err_evt,
  input wire logic qry_err_evt,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic [7:0] event_flags,
  input wire logic [sec_pkg::SETPT_W-1:0] volt_out,
  input wire logic continuous_arming,
  input wire logic list_dir_up,
  input wire logic display_mode_setting,
  input wire logic op_pending
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic tk;
  logic quiet;
  assign tk = cmd_valid && cmd_ready;
  // a completion or error landing in the read cycle may set new bits
  assign quiet = !exe_err_evt && !dde_err_evt && !qry_err_evt && !op_pending;
  esr_read_a: assert property (tk && cmd_code == CMD_ESR_Q && quiet &&
    !$past(op_pending) && !$past(tk && cmd_code == CMD_OPC) |=>
    rsp_valid && rsp_last && event_flags == 8'h00)
    else $error("event flags not cleared by read");
  unused_bits_a: assert property (!event_flags[6] && !event_flags[1])
    else $error("unused event bit set");
  cmd_err_a: assert property (tk && cmd_code == CMD_UNKNOWN |=>
    event_flags[ESR_CME]) else $error("command error bit missing");
  exe_err_a: assert property (exe_err_evt |=> event_flags[ESR_EXE])
    else $error("execution error bit missing");
  dde_err_a: assert property ($rose(dde_err_evt) |=> event_flags[3])
    else $error("device error bit missing");
  opcq_hold_a: assert property (tk && cmd_code == CMD_OPC_Q |=>
    !cmd_ready) else $error("commands not held after completion query");
  opcq_answer_a: assert property (tk && cmd_code == CMD_OPC_Q &&
    !op_pending |-> ##[1:3] rsp_valid && rsp_data == ASCII_ONE)
    else $error("completion query answer missing");
  opc_free_a: assert property (tk && cmd_code == CMD_OPC |=> cmd_ready)
    else $error("completion command stalled the stream");
  rst_modes_a: assert property (tk && cmd_code == CMD_RST |=>
    !continuous_arming && list_dir_up && display_mode_setting == DISP_NORMAL)
    else $error("reset command modes wrong");
  volt_settle_a: assert property (tk && cmd_code == CMD_VOLT |=>
    op_pending && volt_out == $past(cmd_arg))
    else $error("voltage change did not start settling");
endmodule
bind sec_status_cmd sec_status_cmd_chk sec_status_cmd_chk_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
  .exe_err_evt(exe_err_evt), .dde_err_evt(dde_err_evt),
  .qry_err_evt(qry_err_evt), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .rsp_last(rsp_last), .event_flags(event_flags), .volt_out(volt_out),
  .continuous_arming(continuous_arming), .list_dir_up(list_dir_up),
  .display_mode_setting(display_mode_setting), .op_pending(op_pending)
);

/* File: sec_status_cmd_bench.sv */
// Purpose: self-checking bench of the status and command block
// Assumes: one command in flight, answers captured as they appear
// Notes: settle time is the full 200 cycles, so waits are long
`timescale 1ns/1ps
module sec_status_cmd_bench;
  import sec_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  sec_cmd_t code_in = CMD_CLS;
  logic [ARG_W-1:0] arg_in = ARG_ZERO;
  logic [5:0] evt = 6'h00;
  logic st_fail = 1'b0;
  logic [31:0] cal_wdata = 32'h0000_0000;
  logic cmd_valid, cmd_ready, rsp_valid, rsp_last, arm, list_up, disp;
  logic op_pending;
  sec_cmd_t cmd_code;
  logic [ARG_W-1:0] cmd_arg, volt, curr, ovp, ocp;
  logic [31:0] cal_active;
  logic [7:0] rsp_data, status_byte, event_flags;
  logic [8:0] rsp_q[$];
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 sys_clk = ~sys_clk;
  sec_host_model sec_host_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .start(start), .code_in(code_in), .arg_in(arg_in),
    .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg(cmd_arg));
  sec_status_cmd sec_status_cmd_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
    .cmd_ready(cmd_ready), .exe_err_evt(evt[0]), .dde_err_evt(evt[1]),
    .qry_err_evt(evt[2]), .ques_evt(evt[3]), .serial_poll(evt[4]),
    .oper_evt(evt[5]), .selftest_fail(st_fail), .cal_wdata(cal_wdata),
    .cal_active(cal_active), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .status_byte(status_byte),
    .event_flags(event_flags), .volt_out(volt), .curr_out(curr),
    .ovp_out(ovp), .ocp_out(ocp), .continuous_arming(arm),
    .list_dir_up(list_up), .display_mode_setting(disp),
    .op_pending(op_pending));
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // answers are one-cycle pulses, so every byte is queued with its last flag
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (rsp_valid) begin
      rsp_q.push_back({rsp_last, rsp_data});
    end
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [63:0] exp, got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmd(input sec_cmd_t c, input logic [15:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    start <= 1'b1;
    code_in <= c;
    arg_in <= a;
    @(posedge sys_clk);
    start <= 1'b0;
    #1;
    while (cmd_valid && n < 500) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("command taken", 1'b1, n < 500);
  endtask
  task automatic qry(input sec_cmd_t c, input logic [8:0] exp, string w);
    int n;
    n = 0;
    cmd(c, ARG_ZERO);
    while (rsp_q.size() == 0 && n < 400) begin
      wait_cyc(1);
      n++;
    end
    if (rsp_q.size() == 0) begin
      rsp_q.push_back(9'h1ff);
    end
    chk(w, exp, rsp_q.pop_front());
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge sys_clk);
    evt <= m;
    @(posedge sys_clk);
    evt <= 6'h00;
  endtask
  task automatic t_mask;
    chk("power-on flags", 8'h80, event_flags);
    qry(CMD_ESE_Q, 9'h100, "mask at reset");
    cmd(CMD_ESE, 16'h003c);
    qry(CMD_ESE_Q, 9'h13c, "mask");
    cmd(CMD_ESE, 16'h0100);
    qry(CMD_ESE_Q, 9'h13c, "mask kept");
    qry(CMD_ESR_Q, 9'h190, "flags");
    qry(CMD_ESR_Q, 9'h100, "flags reread");
  endtask
  task automatic t_events;
    cmd(CMD_UNKNOWN, ARG_ZERO);
    pulse(6'h07);
    qry(CMD_ESR_Q, 9'h13c, "error flags");
    cmd(CMD_UNKNOWN, ARG_ZERO);
    wait_cyc(3);
    chk("summary bit", 1'b1, status_byte[STB_ESB]);
    cmd(CMD_CLS, ARG_ZERO);
    wait_cyc(2);
    chk("flags cleared", 8'h00, event_flags);
    chk("status cleared", 8'h00, status_byte);
    qry(CMD_ESE_Q, 9'h13c, "mask after clear");
    cmd(CMD_SRE, 16'h0028);
    qry(CMD_SRE_Q, 9'h128, "service mask");
    pulse(6'h28);
    wait_cyc(3);
    chk("request bit", 1'b1, status_byte[STB_RQS]);
    pulse(6'h10);
    wait_cyc(2);
    chk("request after poll", 1'b0, status_byte[STB_RQS]);
    qry(CMD_STB_Q, 9'h1c8, "status query");
    cmd(CMD_CLS, ARG_ZERO);
    wait_cyc(2);
    chk("status cleared again", 8'h00, status_byte);
  endtask
  task automatic t_opc;
    cmd(CMD_VOLT, 16'h0100);
    cmd(CMD_OPC, ARG_ZERO);
    qry(CMD_ESR_Q, 9'h100, "done bit early");
    wait_cyc(205);
    qry(CMD_ESR_Q, 9'h101, "done bit late");
    cmd(CMD_VOLT, 16'h0200);
    qry(CMD_OPC_Q, 9'h131, "completion answer");
    chk("settled at answer", 1'b0, op_pending);
    qry(CMD_OPC_Q, 9'h131, "idle completion");
  endtask
  task automatic t_store;
    cmd(CMD_VOLT, 16'h0190);
    cmd(CMD_CURR, 16'h00eb);
    cmd(CMD_OVP, 16'h01c2);
    cmd(CMD_OCP, 16'h012c);
    cmd(CMD_SAV, 16'h0028);
    cmd(CMD_ARM, 16'h0001);
    cmd(CMD_RST, ARG_ZERO);
    wait_cyc(2);
    chk("reset setpoints", 64'h0, {volt, curr, ovp, ocp});
    chk("reset modes", {1'b0, LIST_DIR_UP, DISP_NORMAL},
        {arm, list_up, disp});
    cmd(CMD_RCL, 16'h0028);
    wait_cyc(2);
    chk("recall", 64'h0190_00eb_01c2_012c, {volt, curr, ovp, ocp});
    cmd(CMD_RCL, 16'h0029);
    qry(CMD_ESR_Q, 9'h110, "bad location");
    cmd(CMD_VTRIG, 16'h0138);
    cmd(CMD_TRG, ARG_ZERO);
    wait_cyc(2);
    chk("unarmed trigger", 16'h0190, volt);
    cmd(CMD_ARM, 16'h0001);
    cmd(CMD_TRG, ARG_ZERO);
    wait_cyc(2);
    chk("armed trigger", 16'h0138, volt);
  endtask
  task automatic t_misc;
    int commas;
    int lasts;
    logic [8:0] b;
    for (int i = 1; i <= 4; i++) begin
      @(posedge sys_clk);
      cal_wdata <= 32'h0000_00a0 + i;
      cmd(CMD_CAL_SAVE, ARG_ZERO);
    end
    wait_cyc(2);
    chk("saved cal", 32'h0000_00a4, cal_active);
    cmd(CMD_CAL_COPY, 16'h0002);
    wait_cyc(2);
    chk("oldest copied", 32'h0000_00a2, cal_active);
    cmd(CMD_CAL_COPY, 16'h0001);
    wait_cyc(2);
    chk("prior copied", 32'h0000_00a4, cal_active);
    cmd(CMD_CAL_COPY, 16'h0003);
    wait_cyc(2);
    chk("factory copied", 32'h0000_0000, cal_active);
    cmd(CMD_CAL_COPY, 16'h0001);
    wait_cyc(2);
    chk("prior after factory", 32'h0000_00a4, cal_active);
    cmd(CMD_CAL_COPY, 16'h0006);
    qry(CMD_ESR_Q, 9'h110, "bad slot");
    chk("slot kept", 32'h0000_00a4, cal_active);
    qry(CMD_TST_Q, 9'h100, "self-test pass");
    @(posedge sys_clk);
    st_fail <= 1'b1;
    qry(CMD_TST_Q, 9'h101, "self-test fail");
    commas = 0;
    lasts = 0;
    cmd(CMD_IDN_Q, ARG_ZERO);
    wait_cyc(45);
    chk("identity length", 41, rsp_q.size());
    while (rsp_q.size() > 0) begin
      b = rsp_q.pop_front();
      commas += (b[7:0] == 8'h2c);
      lasts += b[8];
    end
    chk("identity fields", 3, commas);
    chk("identity end", 2'h3, {lasts == 1, b[8]});
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_cyc(3);
    t_mask();
    t_events();
    t_opc();
    t_store();
    t_misc();
    print_verdict();
  end
endmodule

/* File: sec_store_if.sv */
// Purpose: carrier between the command core and its two storage blocks
// Assumes: all signals in the sys_clk domain
// Notes: strobes are one-cycle pulses from the core
`timescale 1ns/1ps
interface sec_store_if #(parameter int CAL_W = 32);
  import sec_pkg::*;
  logic cal_save;
  logic cal_copy;
  sec_slot_t cal_src;
  logic [CAL_W-1:0] cal_wdata;
  logic [CAL_W-1:0] cal_work;
  logic set_wr;
  logic [LOC_W-1:0] set_loc;
  sec_setpt_t set_wdata;
  sec_setpt_t set_rdata;
  modport ctrl(output cal_save, cal_copy, cal_src, cal_wdata, set_wr, set_loc,
               set_wdata, input cal_work, set_rdata);
  modport cal(input cal_save, cal_copy, cal_src, cal_wdata, output cal_work);
  modport mem(input set_wr, set_loc, set_wdata, output set_rdata);
endinterface
